// ### logic/sfc_frontend.sv
// Purpose: Device-side serial command front end of a serial flash memory.
// Assumes: Serial clock is the link clock; array logic runs on clk and answers rd_req next cycle.
// Notes:   Frame logic is cleared asynchronously while chip select is high.
//          Commands, program bytes and read-word fetches cross to clk by toggles.
//
// Summary of operation
// - Four lines: select, clock, in, out.
// - Dual program turns output pin into input.
// - Dual read turns input pin into output.
// - Only modes zero and three are used.
// - Sample on rising edge, drive on falling.
// - All bytes travel most significant bit first.
// - Releasing select ends the current frame.
// - Unknown opcode ignored until next select.
// - Truncated opcode or address starts nothing.
// - Top two address bits are ignored.
// - Fast read needs two dummy bytes.
// - Standard read needs one dummy byte.
// - Slow read returns data right after address.
// - Dual read: one dummy, two bits per clock.
// - Three block erase sizes, address only.
// - Two chip erase opcodes, opcode only.
// - Program takes address then data bytes.
// - Dual program takes data two bits per clock.
// - Suspend and resume are opcode only.
// - Read streams data; release floats output.
`timescale 1ns/1ps

module sfc_frontend (
	// System clock and reset.
	input  wire logic                      clk,
	input  wire logic                      rstn,
	// Serial link pins.
	input  wire logic                      sck,
	input  wire logic                      cs_n,
	input  wire logic                      host_to_dev,
	output logic                           dual_out_lane0,
	output logic                           dual_out_lane0_oe,
	output logic                           dev_to_host,
	output logic                           dev_to_host_oe,
	input  wire logic                      dual_in_lane1,
	// Command and program data toward the array.
	output logic                           cmd_valid,
	output sfc_pkg::sfc_cmd_t              cmd,
	output logic                           wr_valid,
	output logic [sfc_pkg::BYTE_W-1:0]     wr_data,
	output logic                           frame_end,
	// Array read port.
	output logic                           rd_req,
	output logic [sfc_pkg::ADDR_W-1:0]     rd_addr,
	input  wire logic [sfc_pkg::BYTE_W-1:0] rd_data
);
	import sfc_pkg::*;

	// Frame states of the link logic.
	// The ignore state absorbs every bit until the frame is released.
	typedef enum logic [2:0] {
		ST_OPC    = 3'h0,
		ST_ADDR   = 3'h1,
		ST_DUMMY  = 3'h2,
		ST_WDATA  = 3'h3,
		ST_RDATA  = 3'h4,
		ST_IGNORE = 3'h5
	} sfc_state_t;

	// Link domain, clocked by the serial clock.
	// All registers here except the toggles, held words and the clk-side rd_word_ff clear with the frame.

	sfc_state_t             state_ff;
	sfc_state_t             nxt_state;
	sfc_kind_t              kind_ff;
	logic [BYTE_W-1:0]      rx_ff;
	logic [BITCNT_W-1:0]    bit_ff;
	logic [BYTECNT_W-1:0]   byte_ff;
	logic [15:0]            addr_hi_ff;
	logic [BYTE_W-1:0]      tx_ff;
	logic [BITCNT_W-1:0]    txbit_ff;
	logic                   cmd_tgl_ff;
	sfc_cmd_t               cmd_hold_ff;
	logic                   wr_tgl_ff;
	logic [BYTE_W-1:0]      wr_hold_ff;
	logic                   fetch_tgl_ff;
	logic [BYTE_W-1:0]      rd_word_ff;

	// Link logic is held clear whenever the frame is not open.
	// Because the clear is asynchronous, a frame cut at any bit leaves no partial opcode,
	// address or byte count behind, and the next select always starts at the opcode.
	// The link clock may stop while the select is high, so leaving a frame must not
	// depend on a clock edge.
	wire link_rst_n = rstn & ~cs_n;

	// Lane mode and byte assembly for the current clock.
	// In dual program the higher bit of each pair arrives on lane one, so a pair shifts
	// in as lane one then the input line; every other state takes one bit per edge.
	wire       dual_in   = (state_ff == ST_WDATA) && (kind_ff == CK_PROG_DUAL);
	wire       dual_out  = (kind_ff == CK_READ_DUAL);
	wire [2:0] rx_step   = dual_in ? STEP_DUAL : STEP_SINGLE;
	wire [7:0] rx_single = {rx_ff[6:0], host_to_dev};
	wire [7:0] rx_double = {rx_ff[5:0], dual_in_lane1, host_to_dev};
	wire [7:0] rx_nxt    = dual_in ? rx_double : rx_single;
	wire [2:0] bit_nxt   = bit_ff + rx_step;
	wire       byte_done = (bit_nxt == '0);

	// Decode of the completed opcode and of each command's layout.
	// The opcode is decoded from the shift value that includes the bit arriving now, so
	// the kind is known at the very edge that completes the opcode byte. Opcode-only
	// commands issue at that edge; addressed commands issue at the last address bit.
	wire sfc_kind_t opc_kind = sfc_decode(rx_nxt);
	wire opc_no_addr = (opc_kind == CK_ERASE_CHIP) || (opc_kind == CK_SUSPEND)
		|| (opc_kind == CK_RESUME);
	wire is_read = (kind_ff == CK_READ_FAST) || (kind_ff == CK_READ)
		|| (kind_ff == CK_READ_SLOW) || (kind_ff == CK_READ_DUAL);
	wire is_prog = (kind_ff == CK_PROG) || (kind_ff == CK_PROG_DUAL);
	wire [1:0] dummy_need = (kind_ff == CK_READ_FAST) ? DUMMY_FAST :
		((kind_ff == CK_READ) || (kind_ff == CK_READ_DUAL)) ? DUMMY_ONE :
		DUMMY_NONE;
	wire addr_done  = (state_ff == ST_ADDR) && byte_done && (byte_ff == ADDR_BYTES_LAST);
	wire opc_done   = (state_ff == ST_OPC) && byte_done;
	wire dummy_done = (state_ff == ST_DUMMY) && byte_done && (byte_ff == dummy_need - 2'h1);
	wire [ADDR_W-1:0] full_addr = {addr_hi_ff[ADDR_W-9:0], rx_nxt};
	wire issue_now  = addr_done || (opc_done && opc_no_addr && (opc_kind != CK_NONE));
	wire sfc_kind_t issue_kind = opc_done ? opc_kind : kind_ff;
	wire wr_done    = (state_ff == ST_WDATA) && byte_done;

	// Next frame state.
	// Every path that does not lead on to address, dummy or data ends in the ignore state,
	// which only the select release leaves, so stray trailing bits start nothing.
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_OPC: begin
				if (byte_done) begin
					if (opc_kind == CK_NONE) begin
						nxt_state = ST_IGNORE;
					end else if (opc_no_addr) begin
						nxt_state = ST_IGNORE;
					end else begin
						nxt_state = ST_ADDR;
					end
				end
			end
			ST_ADDR: begin
				if (addr_done) begin
					if (dummy_need != DUMMY_NONE) begin
						nxt_state = ST_DUMMY;
					end else if (is_read) begin
						nxt_state = ST_RDATA;
					end else if (is_prog) begin
						nxt_state = ST_WDATA;
					end else begin
						nxt_state = ST_IGNORE;
					end
				end
			end
			ST_DUMMY: begin
				if (dummy_done) begin
					nxt_state = ST_RDATA;
				end
			end
			ST_WDATA:  nxt_state = ST_WDATA;
			ST_RDATA:  nxt_state = ST_RDATA;
			ST_IGNORE: nxt_state = ST_IGNORE;
			default:   nxt_state = ST_IGNORE;
		endcase
	end

	// Frame state, bit counters and address assembly, sampled on the rising edge.
	// Modes zero and three differ only in the clock idle level, so both use these edges.
	always_ff @(posedge sck or negedge link_rst_n) begin
		if (!link_rst_n) begin
			state_ff   <= ST_OPC;
			kind_ff    <= CK_NONE;
			rx_ff      <= '0;
			bit_ff     <= '0;
			byte_ff    <= '0;
			addr_hi_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			rx_ff    <= rx_nxt;
			bit_ff   <= bit_nxt;
			if (opc_done) begin
				kind_ff <= opc_kind;
			end
			if (byte_done && ((state_ff == ST_ADDR) || (state_ff == ST_DUMMY))) begin
				byte_ff <= (addr_done || dummy_done) ? 2'h0 : byte_ff + 2'h1;
			end
			if ((state_ff == ST_ADDR) && byte_done) begin
				addr_hi_ff <= {addr_hi_ff[7:0], rx_nxt};
			end
		end
	end

	// Event toggles and held words; reset only by rstn so a frame end makes no false edge.
	// Each event flips a toggle instead of raising a pulse, so the system side sees a
	// level change that survives the link clock stopping. The held words are written at
	// the same edge and stay put until the next event, so they can be read without a
	// synchroniser once the toggle change has been synchronised.
	always_ff @(posedge sck or negedge rstn) begin
		if (!rstn) begin
			cmd_tgl_ff  <= 1'b0;
			cmd_hold_ff <= '0;
			wr_tgl_ff   <= 1'b0;
			wr_hold_ff  <= '0;
		end else begin
			if (issue_now && link_rst_n) begin
				cmd_tgl_ff  <= ~cmd_tgl_ff;
				cmd_hold_ff <= '{kind: issue_kind, addr: opc_done ? '0 : full_addr};
			end
			if (wr_done && link_rst_n) begin
				wr_tgl_ff  <= ~wr_tgl_ff;
				wr_hold_ff <= rx_nxt;
			end
		end
	end

	// Read shifter and pin drivers, updated on the falling edge.
	// The first byte is loaded at the falling edge after the last address or dummy bit,
	// so the prefetched word must be ready within half a link clock period; clk has to
	// run several times faster than the link clock for that to hold.
	wire       rd_active = (state_ff == ST_RDATA);
	wire [2:0] tx_step   = dual_out ? STEP_DUAL : STEP_SINGLE;
	wire       tx_load   = rd_active && (txbit_ff == '0);
	wire [7:0] tx_src    = tx_load ? rd_word_ff : tx_ff;
	always_ff @(negedge sck or negedge link_rst_n) begin
		if (!link_rst_n) begin
			tx_ff             <= '0;
			txbit_ff          <= '0;
			dev_to_host       <= 1'b0;
			dev_to_host_oe    <= 1'b0;
			dual_out_lane0    <= 1'b0;
			dual_out_lane0_oe <= 1'b0;
		end else begin
			dev_to_host_oe    <= rd_active;
			dual_out_lane0_oe <= rd_active && dual_out;
			if (rd_active) begin
				dev_to_host    <= tx_src[7];
				dual_out_lane0 <= tx_src[6];
				tx_ff          <= dual_out ? {tx_src[5:0], 2'b00} : {tx_src[6:0], 1'b0};
				txbit_ff       <= txbit_ff + tx_step;
			end
		end
	end

	// Byte-consumed toggle toward the array side.
	// It tells the system side that the prefetched word was taken and the next may come.
	always_ff @(negedge sck or negedge rstn) begin
		if (!rstn) begin
			fetch_tgl_ff <= 1'b0;
		end else if (tx_load && link_rst_n) begin
			fetch_tgl_ff <= ~fetch_tgl_ff;
		end
	end

	// System domain, clocked by clk.
	// Registers here see link events only through the synchronisers below.

	logic [3:0]        sync1_ff;
	logic [3:0]        sync2_ff;
	logic [3:0]        sync3_ff;
	logic              rd_pend_ff;
	logic              rd_stream_ff;

	// Two-flop synchronisers for chip select and the three toggles; third stage for edges.
	// Only the second stage reads the first. Reset values match the idle pins and the
	// reset toggles, so no false event follows reset.
	wire [3:0] sync_in = {cs_n, fetch_tgl_ff, wr_tgl_ff, cmd_tgl_ff};
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sync1_ff <= 4'h8;
			sync2_ff <= 4'h8;
			sync3_ff <= 4'h8;
		end else begin
			sync1_ff <= sync_in;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
		end
	end

	// Edge decode of synchronised events.
	// Each toggle change becomes a one-cycle event; a select rise marks the frame end.
	wire [3:0] sync_edge = sync2_ff ^ sync3_ff;
	wire       cmd_evt   = sync_edge[0];
	wire       wr_evt    = sync_edge[1];
	wire       fetch_evt = sync_edge[2];
	wire       cs_rise   = sync_edge[3] && sync2_ff[3];
	wire       cmd_read  = (cmd_hold_ff.kind == CK_READ_FAST) || (cmd_hold_ff.kind == CK_READ)
		|| (cmd_hold_ff.kind == CK_READ_SLOW) || (cmd_hold_ff.kind == CK_READ_DUAL);

	// Command and program data outputs.
	// Pulses last one cycle; the command and program byte hold until the next event.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cmd_valid <= 1'b0;
			cmd       <= '0;
			wr_valid  <= 1'b0;
			wr_data   <= '0;
			frame_end <= 1'b0;
		end else begin
			cmd_valid <= cmd_evt;
			wr_valid  <= wr_evt;
			frame_end <= cs_rise;
			if (cmd_evt) begin
				cmd <= cmd_hold_ff;
			end
			if (wr_evt) begin
				wr_data <= wr_hold_ff;
			end
		end
	end

	// Read prefetch: fetch at the start address, then one ahead per consumed byte.
	// A new read command wins over a frame end in the same cycle, so the first word of
	// a read is always requested; the address wraps from the top location to zero.
	// The array answers in the cycle after the request and the word is taken one later.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rd_req       <= 1'b0;
			rd_addr      <= '0;
			rd_pend_ff   <= 1'b0;
			rd_stream_ff <= 1'b0;
			rd_word_ff   <= '0;
		end else begin
			rd_req     <= 1'b0;
			rd_pend_ff <= rd_req;
			if (rd_pend_ff) begin
				rd_word_ff <= rd_data;
			end
			if (cmd_evt && cmd_read) begin
				rd_stream_ff <= 1'b1;
				rd_addr      <= cmd_hold_ff.addr;
				rd_req       <= 1'b1;
			end else if (cs_rise) begin
				rd_stream_ff <= 1'b0;
			end else if (fetch_evt && rd_stream_ff) begin
				rd_addr <= rd_addr + 22'h1;
				rd_req  <= 1'b1;
			end
		end
	end

endmodule

// ### logic/sfc_pkg.sv
// Purpose: Shared constants, command kinds and carriers of the serial flash command front end.
// Assumes: Opcodes are 8 bits wide and array addresses are 22 bits wide.
// Notes:   The decode helpers are shared by the link logic and by any bench model.
package sfc_pkg;

	// Field widths.
	localparam int OPC_W     = 8;
	localparam int ADDR_W    = 22;
	localparam int BYTE_W    = 8;
	localparam int BITCNT_W  = 3;
	localparam int BYTECNT_W = 2;

	// Supported opcodes.
	localparam logic [7:0] OPC_READ_FAST  = 8'h1b;
	localparam logic [7:0] OPC_READ       = 8'h0b;
	localparam logic [7:0] OPC_READ_SLOW  = 8'h03;
	localparam logic [7:0] OPC_READ_DUAL  = 8'h3b;
	localparam logic [7:0] OPC_ERASE_4K   = 8'h20;
	localparam logic [7:0] OPC_ERASE_32K  = 8'h52;
	localparam logic [7:0] OPC_ERASE_64K  = 8'hd8;
	localparam logic [7:0] OPC_ERASE_CHIP = 8'h60;
	localparam logic [7:0] OPC_ERASE_ALT  = 8'hc7;
	localparam logic [7:0] OPC_PROG       = 8'h02;
	localparam logic [7:0] OPC_PROG_DUAL  = 8'ha2;
	localparam logic [7:0] OPC_SUSPEND    = 8'hb0;
	localparam logic [7:0] OPC_RESUME     = 8'hd0;

	// Frame layout counts.
	localparam logic [1:0] ADDR_BYTES_LAST = 2'h2;
	localparam logic [1:0] DUMMY_FAST      = 2'h2;
	localparam logic [1:0] DUMMY_ONE       = 2'h1;
	localparam logic [1:0] DUMMY_NONE      = 2'h0;
	localparam logic [2:0] STEP_SINGLE     = 3'h1;
	localparam logic [2:0] STEP_DUAL       = 3'h2;

	// Decoded command kinds.
	typedef enum logic [3:0] {
		CK_NONE       = 4'h0,
		CK_READ_FAST  = 4'h1,
		CK_READ       = 4'h2,
		CK_READ_SLOW  = 4'h3,
		CK_READ_DUAL  = 4'h4,
		CK_ERASE_4K   = 4'h5,
		CK_ERASE_32K  = 4'h6,
		CK_ERASE_64K  = 4'h7,
		CK_ERASE_CHIP = 4'h8,
		CK_PROG       = 4'h9,
		CK_PROG_DUAL  = 4'ha,
		CK_SUSPEND    = 4'hb,
		CK_RESUME     = 4'hc
	} sfc_kind_t;

	// Command handed to the array side.
	typedef struct packed {
		sfc_kind_t           kind;
		logic [ADDR_W-1:0]   addr;
	} sfc_cmd_t;

	// Maps an opcode byte to its command kind.
	function automatic sfc_kind_t sfc_decode(input logic [7:0] opc);
		case (opc)
			OPC_READ_FAST:  sfc_decode = CK_READ_FAST;
			OPC_READ:       sfc_decode = CK_READ;
			OPC_READ_SLOW:  sfc_decode = CK_READ_SLOW;
			OPC_READ_DUAL:  sfc_decode = CK_READ_DUAL;
			OPC_ERASE_4K:   sfc_decode = CK_ERASE_4K;
			OPC_ERASE_32K:  sfc_decode = CK_ERASE_32K;
			OPC_ERASE_64K:  sfc_decode = CK_ERASE_64K;
			OPC_ERASE_CHIP: sfc_decode = CK_ERASE_CHIP;
			OPC_ERASE_ALT:  sfc_decode = CK_ERASE_CHIP;
			OPC_PROG:       sfc_decode = CK_PROG;
			OPC_PROG_DUAL:  sfc_decode = CK_PROG_DUAL;
			OPC_SUSPEND:    sfc_decode = CK_SUSPEND;
			OPC_RESUME:     sfc_decode = CK_RESUME;
			default:        sfc_decode = CK_NONE;
		endcase
	endfunction

endpackage

// ### verification/sfc_frontend_asserts.sv
// Purpose: Port checks on the serial flash command front end.
// Assumes: Array side runs on clk; link effects are judged there.
// Notes:   Bound to every front end instance.
`timescale 1ns/1ps
module sfc_chk (
	// System clock and reset.
	input wire logic                       clk,
	input wire logic                       rstn,
	// Link select and drive enables.
	input wire logic                       cs_n,
	input wire logic                       dual_out_lane0_oe,
	input wire logic                       dev_to_host_oe,
	// Array side.
	input wire logic                       cmd_valid,
	input wire sfc_pkg::sfc_cmd_t          cmd,
	input wire logic                       wr_valid,
	input wire logic                       frame_end,
	input wire logic                       rd_req,
	input wire logic [sfc_pkg::ADDR_W-1:0] rd_addr
);
	import sfc_pkg::*;
	logic              first_ff;
	logic [ADDR_W-1:0] last_ff;
	// Command class decode used by several checks.
	wire is_rd = cmd.kind inside {CK_READ_FAST, CK_READ, CK_READ_SLOW, CK_READ_DUAL};
	wire no_addr = cmd.kind inside {CK_ERASE_CHIP, CK_SUSPEND, CK_RESUME};
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// Remembers whether the next read request is the first of a command.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			first_ff <= 1'b0;
			last_ff  <= '0;
		end else begin
			first_ff <= cmd_valid ? ~rd_req : (first_ff & ~rd_req);
			if (rd_req) last_ff <= rd_addr;
		end
	end
	a_oe_idle: assert property (cs_n |-> !dev_to_host_oe && !dual_out_lane0_oe)
		else $error("Drive enable high while deselected");
	a_lane0_dual: assert property (dual_out_lane0_oe |-> dev_to_host_oe && cmd.kind == CK_READ_DUAL)
		else $error("Lane0 driven outside dual read");
	a_rd_kind: assert property (rd_req |-> is_rd)
		else $error("Read request for a non-read command");
	a_wr_kind: assert property (wr_valid |-> cmd.kind inside {CK_PROG, CK_PROG_DUAL})
		else $error("Program byte for a non-program command");
	a_noaddr_zero: assert property (cmd_valid && no_addr |-> cmd.addr == '0)
		else $error("Opcode-only command carries an address");
	a_first_rd: assert property (cmd_valid && is_rd |-> ##[0:2] rd_req && rd_addr == cmd.addr)
		else $error("First read address wrong");
	a_rd_step: assert property (rd_req && !first_ff && !cmd_valid |-> rd_addr == last_ff + 22'h1)
		else $error("Read address did not step by one");
	a_frame_end: assert property ($rose(cs_n) |-> ##[1:8] frame_end)
		else $error("No frame end after deselect");
	c_dual: cover property (cmd_valid && cmd.kind == CK_READ_DUAL);
	c_prog: cover property (wr_valid && cmd.kind == CK_PROG_DUAL);
	c_short: cover property (cmd_valid && no_addr);
endmodule
bind sfc_frontend sfc_chk CHK (.clk, .rstn, .cs_n, .dual_out_lane0_oe, .dev_to_host_oe,
	.cmd_valid, .cmd, .wr_valid, .frame_end, .rd_req, .rd_addr);

// ### verification/sfc_frontend_tb_top.sv
// Purpose: Self-checking bench for the serial flash command front end.
// Assumes: Array model answers low address byte xor 5a a cycle after rd_req.
// Notes:   Frames use link modes 0 and 3; program frames run in mode 0, short frames in mode 3.
`timescale 1ns/1ps
module sfc_frontend_tb_top;
	import sfc_pkg::*;
	logic clk, rstn, sck, cs_n, host_to_dev, dual_out_lane0, dual_out_lane0_oe;
	logic dev_to_host, dev_to_host_oe, dual_in_lane1, cmd_valid, wr_valid, frame_end, rd_req;
	logic [BYTE_W-1:0] wr_data, rd_data;
	logic [ADDR_W-1:0] rd_addr;
	sfc_cmd_t          cmd, got;
	int                n_cmd, n_end, err_count, checked;
	logic [7:0]        wq[$], rxq[$];
	sfc_frontend DUT (.clk, .rstn, .sck, .cs_n, .host_to_dev, .dual_out_lane0, .dual_out_lane0_oe,
		.dev_to_host, .dev_to_host_oe, .dual_in_lane1, .cmd_valid, .cmd, .wr_valid, .wr_data,
		.frame_end, .rd_req, .rd_addr, .rd_data);
	sfc_host_model HOST (.sck, .cs_n, .host_to_dev, .dual_in_lane1, .dual_out_lane0,
		.dual_out_lane0_oe, .dev_to_host, .dev_to_host_oe);
	// System clock, 4 ns period.
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Array model and capture of the array-side outputs.
	always @(posedge clk) begin
		rd_data <= rd_addr[7:0] ^ 8'h5a;
		if (cmd_valid) begin
			n_cmd++;
			got = cmd;
		end
		if (wr_valid) wq.push_back(wr_data);
		if (frame_end) n_end++;
	end
	// Compares one value and counts the outcome.
	task chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One whole frame: opcode, address, dummies, then data bytes.
	task frame(input logic m3, input logic [7:0] opc, input int na, input int nd,
		input int nx, input logic dual, input logic [23:0] a);
		logic [7:0] r;
		int i;
		rxq.delete();
		wq.delete();
		n_cmd = 0;
		n_end = 0;
		HOST.begin_frame(m3);
		HOST.xbyte(opc, 1'b0, r);
		for (i = 0; i < na; i++) HOST.xbyte(a[23-8*i -: 8], 1'b0, r);
		for (i = 0; i < nd; i++) HOST.xbyte(8'hff, 1'b0, r);
		for (i = 0; i < nx; i++) begin
			HOST.xbyte(8'h96 + i[7:0], dual, r);
			rxq.push_back(r);
		end
		HOST.end_frame();
		repeat (12) @(posedge clk);
	endtask
	// Unknown opcode followed by opcode-like bytes, then a cut address.
	task s_refuse();
		frame(1'b0, 8'h9f, 3, 0, 2, 1'b0, 24'h0b0b0b);
		chk("unknown cmds", 32'h0, n_cmd);
		chk("unknown wr", 32'h0, wq.size());
		chk("unknown end", 32'h1, n_end);
		frame(1'b1, OPC_READ, 2, 0, 0, 1'b0, 24'h000000);
		chk("cut cmds", 32'h0, n_cmd);
		chk("cut end", 32'h1, n_end);
	endtask
	// Read from the top address, wrapping to zero on the second byte.
	task s_read(input logic [7:0] opc, input int nd, input logic dual, input sfc_kind_t k,
		input logic m3);
		frame(m3, opc, 3, nd, 2, dual, 24'hffffff);
		chk("read cmds", 32'h1, n_cmd);
		chk("read end", 32'h1, n_end);
		chk("read kind", k, got.kind);
		chk("read addr", 22'h3fffff, got.addr);
		chk("read byte0", 8'ha5, rxq[0]);
		chk("read wrap", 8'h5a, rxq[1]);
		chk("read oe", 32'h0, {dev_to_host_oe, dual_out_lane0_oe});
	endtask
	// Program with two data bytes.
	task s_prog(input logic [7:0] opc, input logic dual, input sfc_kind_t k);
		frame(1'b0, opc, 3, 0, 2, dual, 24'hc12345);
		chk("prog kind", k, got.kind);
		chk("prog addr", 22'h012345, got.addr);
		chk("prog count", 32'h2, wq.size());
		chk("prog byte0", 8'h96, wq[0]);
		chk("prog byte1", 8'h97, wq[1]);
	endtask
	// Erase, suspend and resume, with one trailing byte that must be ignored.
	task s_short(input logic [7:0] opc, input int na, input sfc_kind_t k);
		frame(1'b1, opc, na, 0, 1, 1'b0, 24'h6a5a5a);
		chk("short cmds", 32'h1, n_cmd);
		chk("short end", 32'h1, n_end);
		chk("short kind", k, got.kind);
		chk("short addr", na ? 22'h2a5a5a : 22'h0, got.addr);
		chk("short wr", 32'h0, wq.size());
	endtask
	// Prints the counts and the verdict, then stops.
	task results();
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// Cuts a hang short.
	initial begin
		#400000;
		err_count++;
		results();
	end
	// Main sequence.
	initial begin
		rstn = 1'b0;
		err_count = 0;
		checked = 0;
		n_cmd = 0;
		n_end = 0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		chk("idle", 32'h0, {cmd_valid, wr_valid, rd_req, frame_end, dev_to_host_oe});
		s_refuse();
		s_read(OPC_READ_SLOW, 0, 1'b0, CK_READ_SLOW, 1'b0);
		s_read(OPC_READ, 1, 1'b0, CK_READ, 1'b1);
		s_read(OPC_READ_FAST, 2, 1'b0, CK_READ_FAST, 1'b0);
		s_read(OPC_READ_DUAL, 1, 1'b1, CK_READ_DUAL, 1'b1);
		s_prog(OPC_PROG, 1'b0, CK_PROG);
		s_prog(OPC_PROG_DUAL, 1'b1, CK_PROG_DUAL);
		s_short(OPC_ERASE_4K, 3, CK_ERASE_4K);
		s_short(OPC_ERASE_32K, 3, CK_ERASE_32K);
		s_short(OPC_ERASE_64K, 3, CK_ERASE_64K);
		s_short(OPC_ERASE_CHIP, 0, CK_ERASE_CHIP);
		s_short(OPC_ERASE_ALT, 0, CK_ERASE_CHIP);
		s_short(OPC_SUSPEND, 0, CK_SUSPEND);
		s_short(OPC_RESUME, 0, CK_RESUME);
		results();
	end
endmodule

// ### verification/sfc_host_model.sv
// Purpose: Host serial master model driving the front end link.
// Assumes: Link clock runs at 64 ns only inside frames, modes 0 and 3.
// Notes:   The output line, while the device has released it, reads as the inverse of its level.
`timescale 1ns/1ps
module sfc_host_model (
	// Link pins toward the device.
	output logic      sck,
	output logic      cs_n,
	output logic      host_to_dev,
	output logic      dual_in_lane1,
	// Device drive and enables.
	input wire logic  dual_out_lane0,
	input wire logic  dual_out_lane0_oe,
	input wire logic  dev_to_host,
	input wire logic  dev_to_host_oe
);
	logic si_ff;
	logic lane1_ff;
	logic mode_ff;
	// Wire levels: the party holding the enable wins each line.
	assign host_to_dev = dual_out_lane0_oe ? dual_out_lane0 : si_ff;
	assign dual_in_lane1 = dev_to_host_oe ? dev_to_host : lane1_ff;
	wire so_w = dev_to_host_oe ? dev_to_host : ~dev_to_host;
	// Idle link: deselected, clock still.
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si_ff = 1'b0;
		lane1_ff = 1'b0;
		mode_ff = 1'b0;
	end
	// Selects the device with the clock at the idle level of the mode.
	task begin_frame(input logic m3);
		mode_ff = m3;
		sck = m3;
		#5.3 cs_n = 1'b0;
		#27 sck = 1'b0;
	endtask
	// Returns the clock to idle, then deselects.
	task end_frame();
		#20 sck = mode_ff;
		#12 cs_n = 1'b1;
		#40;
	endtask
	// One byte, most significant first; dual moves two bits per clock.
	task xbyte(input logic [7:0] tx, input logic dual, output logic [7:0] rx);
		int k;
		rx = 8'h00;
		for (k = 0; k < (dual ? 4 : 8); k++) begin
			if (dual) begin
				lane1_ff = tx[7-2*k];
				si_ff = tx[6-2*k];
			end else begin
				si_ff = tx[7-k];
				lane1_ff = ~lane1_ff;
			end
			#32 sck = 1'b1;
			if (dual) begin
				rx[7-2*k] = so_w;
				rx[6-2*k] = host_to_dev;
			end else rx[7-k] = so_w;
			#32 sck = 1'b0;
		end
	endtask
endmodule
